// >>> verilog/apw_pkg.sv
// Package of the audio pulse-width modulator: register map, field
// positions, reset values, sizes and the control field carrier.
// Assumes one 200 MHz system clock and an Avalon-MM register bus.
package apw_pkg;

    // Byte addresses of the registers on the Avalon-MM bus.
    localparam logic [31:0] APW_CTL_ADDR = 32'h0020_8000;
    localparam logic [31:0] APW_SAMPLE_ADDR = 32'h0020_8004;
    localparam logic [31:0] APW_PERIOD_ADDR = 32'h0020_8008;
    localparam logic [31:0] APW_COUNT_ADDR = 32'h0020_800C;

    // Bit positions inside the control register.
    localparam int APW_HSWAP_BIT = 18;
    localparam int APW_BSWAP_BIT = 17;
    localparam int APW_SWR_BIT = 16;
    localparam int APW_CLKSRC_BIT = 15;
    localparam int APW_PRESC_HI = 14;
    localparam int APW_PRESC_LO = 8;
    localparam int APW_IRQ_BIT = 7;
    localparam int APW_INTERRUPT_REQUEST_ENABLE_BIT = 6;
    localparam int APW_SPACE_BIT = 5;
    localparam int APW_EN_BIT = 4;
    localparam int APW_REP_HI = 3;
    localparam int APW_REP_LO = 2;
    localparam int APW_SEL_HI = 1;
    localparam int APW_SEL_LO = 0;

    // Sample path and sample queue sizes.
    localparam int APW_SAMPLE_W = 16;
    localparam int APW_FIFO_DEPTH = 4;
    localparam int APW_IDX_W = 2;
    localparam int APW_LVL_W = 3;
    localparam logic [APW_LVL_W-1:0] APW_LVL_FULL = 3'h4;
    localparam logic [APW_LVL_W-1:0] APW_LVL_LOW = 3'h1;

    // Values after reset.
    localparam logic [15:0] APW_PERIOD_RESET = 16'hFFFE;
    localparam logic [15:0] APW_PERIOD_TOP = 16'hFFFE;
    localparam logic [15:0] APW_SAMPLE_RESET = 16'h0000;

    // Soft reset lasts this many system clock cycles.
    localparam logic [2:0] APW_SWR_CYCLES = 3'h5;

    // Control fields that software sets.
    typedef struct packed {
        logic hswap;
        logic bswap;
        logic clksrc;
        logic [6:0] prescale;
        logic irq_en;
        logic en;
        logic [1:0] repeat_sel;
        logic [1:0] div_sel;
    } apw_ctl_s;

    localparam apw_ctl_s APW_CTL_RESET = '0;

endpackage

// >>> verilog/apw_top.sv
// Audio pulse-width modulator with a sample queue, sample repeat,
// sampling divider and endian swapping of written samples.
// Assumes an Avalon-MM master on CLK and a low-pass filter on PWM_OUT.
//
// Overview of operation
// - Space flag set means one more word fits; writes without space are dropped.
// - While disabled, writes to every register except control are ignored.
// - Disabled: output low, prescaler and counter held at zero, queue flushed.
// - On enable a new period starts high, counting resumes, request flag sets.
// - Repeat field bits 3-2 set sample reuse; 00 uses each sample once.
// - Divide select bits 1-0 divide sampling by 2, 4, 8 or 16.
// - Byte swap alone exchanges bits 15:8 and 7:0 of written data.
// - Halfword swap alone exchanges bits 31:16 and 15:0 of written data.
// - Both swaps: halfwords exchanged first, then bytes of the lower half.
// - Only the lower 16 bits after swapping enter the sample queue.
// - A sample register write while enabled pushes the value into the queue if it has space.
// - With no new sample, periods repeat at the last applied duty value.
// - Sample above period plus one keeps output high all period.
// - Sample register holds 16 bits; upper bits read zero.
// - Request flag sets at one or zero words, clears on control read.
// - Counter restarts a period when it matches period value plus one.
// - Soft reset bit resets the block and clears after five cycles.
`timescale 1ns/100ps

module apw_top
    import apw_pkg::*;
(
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic [31:0] ADDRESS,
    input wire logic READ,
    input wire logic WRITE,
    input wire logic [31:0] WRITEDATA,
    output logic [31:0] READDATA,
    output logic WAITREQUEST,
    output logic PWM_OUT
);

    // Control state.
    apw_ctl_s ctl;
    logic irq_flag;
    logic [15:0] period;
    logic [15:0] sample_reg;
    logic [2:0] swr_cnt;
    logic en_q;

    // Counting state.
    logic [6:0] presc_cnt;
    logic [15:0] count;
    logic [3:0] slot_cnt;
    logic [2:0] use_cnt;
    logic [15:0] applied;

    // Sample queue.
    logic [APW_SAMPLE_W-1:0] fifo_mem [APW_FIFO_DEPTH];
    logic [APW_IDX_W-1:0] wr_idx;
    logic [APW_IDX_W-1:0] rd_idx;
    logic [APW_LVL_W-1:0] level;

    // Decode and strobes.
    logic blk_rst;
    logic acc;
    logic wr_acc;
    logic rd_acc;
    logic hit_ctl;
    logic hit_sample;
    logic hit_period;
    logic hit_count;
    logic wr_ctl;
    logic wr_other_ok;
    logic push;
    logic pop;
    logic space;
    logic tick;
    logic restart;
    logic slot;
    logic en_rise;
    logic [31:0] hw_swapped;
    logic [15:0] swapped;
    logic [15:0] next_period;
    logic [3:0] slot_div;
    logic [2:0] use_max;
    logic [31:0] next_readdata;

    // Soft reset or pin reset puts control, queue and counting state back to its start; the bus handshake and read data follow the pin reset only.
    assign blk_rst = !RST_N || (swr_cnt != 3'h0);

    // A request is taken at the edge where waitrequest is seen low.
    assign acc = (READ || WRITE) && !WAITREQUEST;
    assign wr_acc = acc && WRITE;
    assign rd_acc = acc && READ;

    // Address decode on whole byte addresses.
    assign hit_ctl = (ADDRESS == APW_CTL_ADDR);
    assign hit_sample = (ADDRESS == APW_SAMPLE_ADDR);
    assign hit_period = (ADDRESS == APW_PERIOD_ADDR);
    assign hit_count = (ADDRESS == APW_COUNT_ADDR);

    // Only the control register listens while the block is off.
    assign wr_ctl = wr_acc && hit_ctl;
    assign wr_other_ok = wr_acc && ctl.en;

    // Queue space and push of written samples.
    assign space = (level < APW_LVL_FULL);
    assign push = wr_other_ok && hit_sample && space;

    // Halfwords exchange first, then bytes of the lower half.
    assign hw_swapped = ctl.hswap ? {WRITEDATA[15:0], WRITEDATA[31:16]}
                                  : WRITEDATA;
    assign swapped = ctl.bswap ? {hw_swapped[7:0], hw_swapped[15:8]}
                               : hw_swapped[15:0];

    // An all-ones period acts as the largest legal value.
    assign next_period = (WRITEDATA[15:0] > APW_PERIOD_TOP) ?
                         APW_PERIOD_TOP : WRITEDATA[15:0];

    // Prescaler tick and period restart.
    assign tick = ctl.en && (presc_cnt == ctl.prescale);
    assign restart = tick &&
        ({1'b0, count} == ({1'b0, period} + 17'h00001));

    // Sampling slot every 2, 4, 8 or 16 periods.
    assign slot_div = 4'(4'h2 << ctl.div_sel);
    assign slot = restart && (slot_cnt == 4'(slot_div - 4'h1));

    // Uses allowed per sample, less one.
    assign use_max = 3'((4'h1 << ctl.repeat_sel) - 4'h1);
    assign pop = slot && (use_cnt >= use_max) &&
                 (level != 3'h0);

    assign en_rise = ctl.en && !en_q;

    // Soft reset counter; only the pin reset clears it.
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            swr_cnt <= 3'h0;
        end else if (swr_cnt != 3'h0) begin
            swr_cnt <= swr_cnt - 3'h1;
        end else if (wr_ctl && WRITEDATA[APW_SWR_BIT]) begin
            swr_cnt <= APW_SWR_CYCLES;
        end
    end

    // Bus handshake: one wait cycle, then one answer cycle.
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            WAITREQUEST <= 1'b1;
        end else if (!WAITREQUEST) begin
            WAITREQUEST <= 1'b1;
        end else if (READ || WRITE) begin
            WAITREQUEST <= 1'b0;
        end
    end

    // Read data are formed while the request waits.
    always_comb begin
        next_readdata = 32'h0000_0000;
        if (hit_ctl) begin
            next_readdata[APW_HSWAP_BIT] = ctl.hswap;
            next_readdata[APW_BSWAP_BIT] = ctl.bswap;
            next_readdata[APW_SWR_BIT] = (swr_cnt != 3'h0);
            next_readdata[APW_CLKSRC_BIT] = ctl.clksrc;
            next_readdata[APW_PRESC_HI:APW_PRESC_LO] = ctl.prescale;
            next_readdata[APW_IRQ_BIT] = irq_flag;
            next_readdata[APW_INTERRUPT_REQUEST_ENABLE_BIT] = ctl.irq_en;
            next_readdata[APW_SPACE_BIT] = space;
            next_readdata[APW_EN_BIT] = ctl.en;
            next_readdata[APW_REP_HI:APW_REP_LO] = ctl.repeat_sel;
            next_readdata[APW_SEL_HI:APW_SEL_LO] = ctl.div_sel;
        end else if (hit_sample) begin
            next_readdata[15:0] = sample_reg;
        end else if (hit_period) begin
            next_readdata[15:0] = period;
        end else if (hit_count) begin
            next_readdata[15:0] = count;
        end
    end

    // Read data register, loaded in the wait cycle.
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            READDATA <= 32'h0000_0000;
        end else if (WAITREQUEST && READ) begin
            READDATA <= next_readdata;
        end
    end

    // Control fields are written whether enabled or not.
    always_ff @(posedge CLK) begin
        if (blk_rst) begin
            ctl <= APW_CTL_RESET;
        end else if (wr_ctl) begin
            ctl.hswap <= WRITEDATA[APW_HSWAP_BIT];
            ctl.bswap <= WRITEDATA[APW_BSWAP_BIT];
            ctl.clksrc <= WRITEDATA[APW_CLKSRC_BIT];
            ctl.prescale <= WRITEDATA[APW_PRESC_HI:APW_PRESC_LO];
            ctl.irq_en <= WRITEDATA[APW_INTERRUPT_REQUEST_ENABLE_BIT];
            ctl.en <= WRITEDATA[APW_EN_BIT];
            ctl.repeat_sel <= WRITEDATA[APW_REP_HI:APW_REP_LO];
            ctl.div_sel <= WRITEDATA[APW_SEL_HI:APW_SEL_LO];
        end
    end

    // Enable history for the start of a new run.
    always_ff @(posedge CLK) begin
        if (blk_rst) begin
            en_q <= 1'b0;
        end else begin
            en_q <= ctl.en;
        end
    end

    // Request flag: set by a low queue, by software or on enable.
    always_ff @(posedge CLK) begin
        if (blk_rst) begin
            irq_flag <= 1'b0;
        end else if (ctl.en && (level <= APW_LVL_LOW)) begin
            irq_flag <= 1'b1;
        end else if (wr_ctl && WRITEDATA[APW_IRQ_BIT]) begin
            irq_flag <= 1'b1;
        end else if (rd_acc && hit_ctl) begin
            irq_flag <= 1'b0;
        end
    end

    // Period register, written only while enabled.
    always_ff @(posedge CLK) begin
        if (blk_rst) begin
            period <= APW_PERIOD_RESET;
        end else if (wr_other_ok && hit_period) begin
            period <= next_period;
        end
    end

    // Sample register keeps the last value that entered the queue.
    always_ff @(posedge CLK) begin
        if (blk_rst) begin
            sample_reg <= APW_SAMPLE_RESET;
        end else if (push) begin
            sample_reg <= swapped;
        end
    end

    // Queue storage, addressed by the write index.
    always_ff @(posedge CLK) begin
        if (push) begin
            fifo_mem[wr_idx] <= swapped;
        end
    end

    // Queue indices and fill level; flushed while disabled.
    always_ff @(posedge CLK) begin
        if (blk_rst || !ctl.en) begin
            wr_idx <= '0;
            rd_idx <= '0;
            level <= '0;
        end else begin
            if (push) begin
                wr_idx <= wr_idx + 2'h1;
            end
            if (pop) begin
                rd_idx <= rd_idx + 2'h1;
            end
            if (push && !pop) begin
                level <= level + 3'h1;
            end else if (pop && !push) begin
                level <= level - 3'h1;
            end
        end
    end

    // Prescaler; held at zero while disabled.
    always_ff @(posedge CLK) begin
        if (blk_rst || !ctl.en) begin
            presc_cnt <= 7'h00;
        end else if (tick) begin
            presc_cnt <= 7'h00;
        end else begin
            presc_cnt <= presc_cnt + 7'h01;
        end
    end

    // Period counter; held at zero while disabled.
    always_ff @(posedge CLK) begin
        if (blk_rst || !ctl.en) begin
            count <= 16'h0000;
        end else if (restart) begin
            count <= 16'h0000;
        end else if (tick) begin
            count <= count + 16'h0001;
        end
    end

    // Period count inside one sampling slot.
    always_ff @(posedge CLK) begin
        if (blk_rst || !ctl.en) begin
            slot_cnt <= 4'h0;
        end else if (slot) begin
            slot_cnt <= 4'h0;
        end else if (restart) begin
            slot_cnt <= slot_cnt + 4'h1;
        end
    end

    // Uses of the applied sample; starts full so the first pops at once.
    always_ff @(posedge CLK) begin
        if (blk_rst || !ctl.en) begin
            use_cnt <= 3'h7;
        end else if (pop) begin
            use_cnt <= 3'h0;
        end else if (slot && (use_cnt < use_max)) begin
            use_cnt <= use_cnt + 3'h1;
        end else if (slot) begin
            use_cnt <= use_max;
        end
    end

    // Applied duty value changes only at a period boundary.
    always_ff @(posedge CLK) begin
        if (blk_rst) begin
            applied <= APW_SAMPLE_RESET;
        end else if (pop) begin
            applied <= fifo_mem[rd_idx];
        end
    end

    // Output pin: high at period start, low at the duty match.
    always_ff @(posedge CLK) begin
        if (blk_rst || !ctl.en) begin
            PWM_OUT <= 1'b0;
        end else if (en_rise || restart) begin
            PWM_OUT <= 1'b1;
        end else if (count == applied) begin
            PWM_OUT <= 1'b0;
        end
    end

endmodule // apw_top

// >>> bench/apw_assertions.sv
// Checker of the modulator bus handshake and output timing.
// Assumes it is bound to apw_top and sees only that module's ports.
`timescale 1ns/100ps
module apw_chk
    import apw_pkg::*;
(
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic [31:0] ADDRESS,
    input wire logic READ,
    input wire logic WRITE,
    input wire logic [31:0] WRITEDATA,
    input wire logic [31:0] READDATA,
    input wire logic WAITREQUEST,
    input wire logic PWM_OUT
);
    logic en_q;
    logic [3:0] swr_age;
    logic rd_ok;
    logic ctl_wr;
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);
    // Accepted reads and accepted control writes.
    assign rd_ok = READ && !WAITREQUEST;
    assign ctl_wr = WRITE && !WAITREQUEST && ADDRESS == APW_CTL_ADDR;
    // Shadow of the enable bit; a soft reset also disables.
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            en_q <= 1'b0;
        end else if (ctl_wr) begin
            en_q <= WRITEDATA[APW_EN_BIT] && !WRITEDATA[APW_SWR_BIT];
        end
    end
    // Cycles since the last soft reset request, saturating.
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            swr_age <= 4'hF;
        end else if (ctl_wr && WRITEDATA[APW_SWR_BIT]) begin
            swr_age <= 4'h0;
        end else if (swr_age != 4'hF) begin
            swr_age <= swr_age + 4'h1;
        end
    end
    sequence s_taken;
        (READ || WRITE) && WAITREQUEST;
    endsequence
    sequence s_answer;
        !WAITREQUEST ##1 WAITREQUEST;
    endsequence
    chk_bus_answer: assert property (s_taken |=> s_answer)
        else $error("bus request not answered in one cycle");
    chk_wait_cause: assert property (
        $fell(WAITREQUEST) |-> $past(READ) || $past(WRITE))
        else $error("answer without a request");
    chk_reset_idle: assert property (
        $rose(RST_N) |-> WAITREQUEST && !PWM_OUT)
        else $error("outputs not idle after reset");
    chk_sample_upper: assert property (
        rd_ok && ADDRESS == APW_SAMPLE_ADDR |-> READDATA[31:16] == 16'h0)
        else $error("sample upper half not zero");
    chk_space_off: assert property (
        rd_ok && ADDRESS == APW_CTL_ADDR && !en_q
        |-> READDATA[APW_SPACE_BIT])
        else $error("queue not flushed while disabled");
    chk_count_frozen: assert property (
        rd_ok && ADDRESS == APW_COUNT_ADDR && !en_q |-> READDATA == 32'h0)
        else $error("counter running while disabled");
    chk_off_low: assert property (!en_q [*2] |-> !PWM_OUT)
        else $error("output high while disabled");
    chk_on_rise: assert property ($rose(en_q) |-> ##[0:2] PWM_OUT)
        else $error("output did not rise on enable");
    chk_swr_ends: assert property (
        rd_ok && ADDRESS == APW_CTL_ADDR && swr_age > 4'h6
        |-> !READDATA[APW_SWR_BIT])
        else $error("soft reset bit did not clear");
endmodule // apw_chk

bind apw_top apw_chk u_chk (
    .CLK(CLK), .RST_N(RST_N), .ADDRESS(ADDRESS), .READ(READ),
    .WRITE(WRITE), .WRITEDATA(WRITEDATA), .READDATA(READDATA),
    .WAITREQUEST(WAITREQUEST), .PWM_OUT(PWM_OUT)
);

// >>> bench/apw_lpf_model.sv
// Load on the modulator output: measures pulse width, period and run.
// Assumes the output is a clean level sampled on the system clock.
`timescale 1ns/100ps
module apw_lpf_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic pwm_in,
    output logic [15:0] hi_len,
    output logic [15:0] per_len,
    output logic [15:0] run_len
);
    logic prev;
    logic [15:0] age;
    logic [15:0] run;
    // Latch widths on each edge and count periods of equal width.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prev <= 1'b0;
            age <= 16'h0;
            hi_len <= 16'h0;
            per_len <= 16'h0;
            run <= 16'h0;
            run_len <= 16'h0;
        end else begin
            prev <= pwm_in;
            age <= age + 16'h1;
            if (pwm_in && !prev) begin
                per_len <= age;
                age <= 16'h1;
            end
            if (!pwm_in && prev) begin
                hi_len <= age;
                run <= (age == hi_len) ? run + 16'h1 : 16'h1;
                if (age != hi_len) begin
                    run_len <= run;
                end
            end
        end
    end
endmodule // apw_lpf_model

// >>> bench/apw_top_tb_top.sv
// Self-checking bench of the audio modulator over its register bus.
// Assumes apw_top, its bound checker and the output load model.
`timescale 1ns/100ps
module apw_top_tb_top
    import apw_pkg::*;
    ;
    logic CLK = 1'b0;
    logic RST_N = 1'b0;
    logic [31:0] ADDRESS = 32'h0;
    logic READ = 1'b0;
    logic WRITE = 1'b0;
    logic [31:0] WRITEDATA = 32'h0;
    logic [31:0] READDATA;
    logic WAITREQUEST;
    logic PWM_OUT;
    logic [15:0] hi_len;
    logic [15:0] per_len;
    logic [15:0] run_len;
    logic [31:0] rd_val;
    int bad_count = 0;
    int total_checks = 0;
    int cyc = 0;
    // Clock, device and output load.
    always #2.5 CLK = ~CLK;
    apw_top u_dut (.CLK(CLK), .RST_N(RST_N), .ADDRESS(ADDRESS),
        .READ(READ), .WRITE(WRITE), .WRITEDATA(WRITEDATA),
        .READDATA(READDATA), .WAITREQUEST(WAITREQUEST), .PWM_OUT(PWM_OUT));
    apw_lpf_model u_load (.clk(CLK), .rst_n(RST_N), .pwm_in(PWM_OUT),
        .hi_len(hi_len), .per_len(per_len), .run_len(run_len));
    // A hung run is cut short after this many cycles.
    always @(posedge CLK) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count = bad_count + 1;
            give_verdict();
        end
    end
    task automatic cmp_word(input string name, input logic [31:0] exp,
        input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    // One bus access, held until the slave drops its wait request.
    task automatic bus(input logic wr, input logic [31:0] a,
        input logic [31:0] d);
        @(posedge CLK);
        ADDRESS <= a;
        WRITEDATA <= d;
        WRITE <= wr;
        READ <= !wr;
        do @(posedge CLK); while (WAITREQUEST !== 1'b0);
        rd_val = READDATA;
        WRITE <= 1'b0;
        READ <= 1'b0;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd_chk(input string n, input logic [31:0] a,
        input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        cmp_word(n, e, rd_val);
    endtask
    task automatic t_reset();
        rd_chk("ctl", APW_CTL_ADDR, 32'h0000_0020);
        rd_chk("unmapped", 32'h0020_8010, 32'h0);
        wr(APW_SAMPLE_ADDR, 32'h0000_1234);
        wr(APW_PERIOD_ADDR, 32'h0000_0008);
        wr(APW_COUNT_ADDR, 32'h0000_0055);
        rd_chk("sample", APW_SAMPLE_ADDR, 32'h0);
        rd_chk("period", APW_PERIOD_ADDR, 32'h0000_FFFE);
        rd_chk("count", APW_COUNT_ADDR, 32'h0);
        $display("test reset done");
    endtask
    task automatic t_swap();
        logic [15:0] tab [4] = '{16'h5678, 16'h7856, 16'h1234, 16'h3412};
        for (int k = 0; k < 4; k++) begin
            wr(APW_CTL_ADDR, (32'(k) << APW_BSWAP_BIT) | 32'h10);
            wr(APW_SAMPLE_ADDR, 32'h1234_5678);
            rd_chk("swap", APW_SAMPLE_ADDR, {16'h0, tab[k]});
            wr(APW_CTL_ADDR, 32'h0);
        end
        $display("test swap done");
    endtask
    task automatic t_fifo();
        wr(APW_CTL_ADDR, 32'h0000_0010);
        for (int i = 1; i <= 5; i++) begin
            wr(APW_SAMPLE_ADDR, 32'(i));
        end
        rd_chk("ctl full", APW_CTL_ADDR, 32'h0000_0090);
        rd_chk("ctl read", APW_CTL_ADDR, 32'h0000_0010);
        wr(APW_CTL_ADDR, 32'h0000_FFD0);
        rd_chk("ctl set", APW_CTL_ADDR, 32'h0000_FFD0);
        wr(APW_PERIOD_ADDR, 32'h0000_FFFF);
        rd_chk("period top", APW_PERIOD_ADDR, 32'h0000_FFFE);
        rd_chk("dropped", APW_SAMPLE_ADDR, 32'h0000_0004);
        wr(APW_CTL_ADDR, 32'h0);
        repeat (3) @(posedge CLK);
        cmp_word("out off", 32'h0, {31'h0, PWM_OUT});
        bus(1'b0, APW_CTL_ADDR, 32'h0);
        cmp_word("flushed", 32'h20, rd_val & 32'hFFFF_FF7F);
        $display("test fifo done");
    endtask
    task automatic t_repeat();
        wr(APW_CTL_ADDR, 32'h0000_0015);
        wr(APW_PERIOD_ADDR, 32'h0000_0008);
        wr(APW_SAMPLE_ADDR, 32'h0000_0003);
        wr(APW_SAMPLE_ADDR, 32'h0000_0006);
        repeat (300) @(posedge CLK);
        cmp_word("reuse", 32'h8, {16'h0, run_len});
        wr(APW_CTL_ADDR, 32'h0);
        $display("test repeat done");
    endtask
    // Prescaler, four uses per sample, and the divide by sixteen slot.
    task automatic t_modes();
        wr(APW_CTL_ADDR, 32'h0000_0118);
        wr(APW_PERIOD_ADDR, 32'h0000_0008);
        wr(APW_SAMPLE_ADDR, 32'h0000_0003);
        wr(APW_SAMPLE_ADDR, 32'h0000_0006);
        repeat (350) @(posedge CLK);
        cmp_word("slow period", 32'h14, {16'h0, per_len});
        cmp_word("reuse four", 32'h8, {16'h0, run_len});
        wr(APW_CTL_ADDR, 32'h0);
        wr(APW_CTL_ADDR, 32'h0000_0013);
        wr(APW_SAMPLE_ADDR, 32'h0000_0003);
        wr(APW_SAMPLE_ADDR, 32'h0000_0006);
        repeat (400) @(posedge CLK);
        cmp_word("div sixteen", 32'h10, {16'h0, run_len});
        wr(APW_CTL_ADDR, 32'h0);
        $display("test modes done");
    endtask
    task automatic t_duty();
        logic [15:0] h3;
        int n = 0;
        wr(APW_CTL_ADDR, 32'h0000_0010);
        wr(APW_PERIOD_ADDR, 32'h0000_0008);
        wr(APW_SAMPLE_ADDR, 32'h0000_0003);
        repeat (100) @(posedge CLK);
        h3 = hi_len;
        cmp_word("period", 32'hA, {16'h0, per_len});
        wr(APW_SAMPLE_ADDR, 32'h0000_0006);
        repeat (100) @(posedge CLK);
        cmp_word("width", 32'h3, {16'h0, hi_len - h3});
        repeat (300) @(posedge CLK);
        cmp_word("held", {16'h0, h3 + 16'h3}, {16'h0, hi_len});
        wr(APW_SAMPLE_ADDR, 32'h0000_0014);
        repeat (60) @(posedge CLK);
        repeat (30) begin
            @(posedge CLK);
            n += (PWM_OUT === 1'b1);
        end
        cmp_word("full duty", 32'h1E, 32'(n));
        wr(APW_CTL_ADDR, 32'h0001_0010);
        repeat (10) @(posedge CLK);
        rd_chk("swr ctl", APW_CTL_ADDR, 32'h0000_0020);
        rd_chk("swr period", APW_PERIOD_ADDR, 32'h0000_FFFE);
        $display("test duty done");
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Reset, then the scenarios in turn.
    initial begin
        repeat (20) @(posedge CLK);
        RST_N <= 1'b1;
        t_reset();
        t_swap();
        t_fifo();
        t_repeat();
        t_modes();
        t_duty();
        give_verdict();
    end
endmodule // apw_top_tb_top
